/* wwdt_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wwdt_checker (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        srst,
    // Register bus.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and watchdog outputs.
    input wire logic        counting_clock,
    input wire logic        sleep_mode,
    input wire logic        chip_reset,
    input wire logic        warning_irq,
    input wire logic        wakeup
);
    import wwdt_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic ever_reg, en_reg, rst_reg, prot_reg, arm_reg, aa_reg;
    // Decode of completed accesses and of the feed sequence.
    wire done = psel && penable && pready;
    wire m_wr = done && pwrite && (paddr == ADDR_MODE);
    wire f_wr = done && pwrite && (paddr == ADDR_FEED);
    wire f_ok = f_wr && aa_reg && (pwdata[7:0] == FEED_SECOND);
    wire bad  = done && aa_reg && !f_ok;
    // Bus-side view of the mode bits, arming and a pending first feed byte.
    always_ff @(posedge clk) begin
        if (srst) begin
            {ever_reg, en_reg, rst_reg, prot_reg, arm_reg, aa_reg} <= 6'h00;
        end else begin
            ever_reg <= ever_reg | (m_wr & pwdata[BIT_RUN_ENABLE]);
            en_reg   <= !chip_reset & (en_reg | (m_wr & pwdata[BIT_RUN_ENABLE]));
            rst_reg  <= !chip_reset & (rst_reg | (m_wr & pwdata[BIT_RESET_ON_TIMEOUT]));
            prot_reg <= !chip_reset & (prot_reg | (m_wr & pwdata[BIT_RELOAD_PROTECT]));
            arm_reg  <= !chip_reset & (arm_reg | (f_ok & en_reg));
            aa_reg   <= !chip_reset & (done ? (f_wr && pwdata[7:0] == FEED_FIRST) : aa_reg);
        end
    end
    // Properties on the outputs.
    property p_idle; !ever_reg |-> !chip_reset && !warning_irq && !wakeup; endproperty
    property p_unarmed; !arm_reg && !prot_reg |-> !chip_reset; endproperty
    property p_int_mode; arm_reg && !rst_reg && !prot_reg |-> !chip_reset; endproperty
    property p_feed_err; bad && arm_reg && rst_reg |-> ##2 chip_reset; endproperty
    property p_rst_pulse; chip_reset |=> !chip_reset; endproperty
    property p_wake; wakeup |-> $past(sleep_mode); endproperty
    property p_irq_en; $rose(warning_irq) |-> en_reg; endproperty
    property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    property p_idle_bus; !pready |-> !pslverr && prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("activity while never enabled");
    a_unarmed: assert property (p_unarmed) else $error("reset before first feed");
    a_int_mode: assert property (p_int_mode) else $error("reset in interrupt mode");
    a_feed_err: assert property (p_feed_err) else $error("feed error reset late");
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    a_wake: assert property (p_wake) else $error("wakeup outside sleep");
    a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
    a_wait: assert property (p_wait) else $error("wait state wrong");
    a_idle_bus: assert property (p_idle_bus) else $error("bus outputs not idle");
    // Main scenarios.
    c_reset: cover property (chip_reset);
    c_irq: cover property ($rose(warning_irq));
    c_wake: cover property (wakeup);
    c_err: cover property (pslverr);
endmodule // wwdt_checker
bind wwdt_top wwdt_checker u_chk (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counting_clock(counting_clock), .sleep_mode(sleep_mode), .chip_reset(chip_reset),
    .warning_irq(warning_irq), .wakeup(wakeup));
`default_nettype wire

/* wwdt_pkg.sv */
// How it works
// - Reload constant accepts writes freely while reload protect is clear.
// - With protect set, reload changes only when counter is below warning and window.
// - Early reload write under protect causes watchdog reset and sets timeout flag.
// - Run enable, reset on timeout and reload protect are set only bits.
// - Timeout flag sets on timeout, feed error, and protected reload write.
// - Software writing zero to bit two of mode clears the timeout flag.
// - Warning flag sets on warning match; cleared by reset or writing one.
// - A watchdog interrupt during Sleep issues a wake up.
// - With run enable low nothing counts or interrupts; only a protected reload write resets.
// - Interrupt mode raises warning flag and interrupt; only a protected reload write resets chip.
// - Reset mode raises warning interrupt and resets chip when counter hits zero.
// - In reset mode a feed above the window compare resets the chip.
// - Every completed feed reloads the counter from the reload constant.
// - Reload constant resets to 0xFF and values below 0xFF store 0xFF.
// - Writing 0xAA then 0x55 to feed is a valid feed and starts counting.
// - Run enable alone does not arm; first valid feed arms resets and errors.
// - After 0xAA, any other access is a feed error setting the timeout flag.
// - Feed error reset is asserted in the second bus cycle after the access.
// - Counter readback resets to 0xFF and lags the live counter slightly.
// - Warning interrupt rises one counting clock cycle after the match.
// - Warning match needs low ten counter bits equal field, upper bits zero.
// - A zero warning field makes the warning match coincide with the timeout.
// - Window compare resets to its maximum so windowing is off.
// - Mode and reload writes reach counting logic after three counting clocks.
// - Run enable and reset on timeout take effect only after a feed sequence; reload protect at once.
// - Counting clock passes a divide by four prescaler before the counter.
package wwdt_pkg;
    localparam logic [31:0] ADDR_MODE     = 32'h4000_4000;
    localparam logic [31:0] ADDR_RELOAD   = 32'h4000_4004;
    localparam logic [31:0] ADDR_FEED     = 32'h4000_4008;
    localparam logic [31:0] ADDR_READBACK = 32'h4000_400C;
    localparam logic [31:0] ADDR_WARN     = 32'h4000_4014;
    localparam logic [31:0] ADDR_WINDOW   = 32'h4000_4018;

    localparam int BIT_RUN_ENABLE     = 0;
    localparam int BIT_RESET_ON_TIMEOUT = 1;
    localparam int BIT_TIMEOUT_FLAG   = 2;
    localparam int BIT_WARNING_FLAG   = 3;
    localparam int BIT_RELOAD_PROTECT = 4;

    localparam int CNT_W  = 24;
    localparam int WARN_W = 10;

    localparam logic [23:0] RELOAD_RESET = 24'h00_00FF;
    localparam logic [23:0] RELOAD_MIN   = 24'h00_00FF;
    localparam logic [23:0] WINDOW_RESET = 24'hFF_FFFF;
    localparam logic [9:0]  WARN_RESET   = 10'h000;
    localparam logic [7:0]  FEED_FIRST   = 8'hAA;
    localparam logic [7:0]  FEED_SECOND  = 8'h55;

    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [1:0] SYNC_DELAY    = 2'h3;

    // Set-only mode bits grouped as one carrier.
    typedef struct packed {
        logic reload_protect;
        logic reset_on_timeout;
        logic run_enable;
    } wwdt_mode_type;

    typedef enum logic {FEED_IDLE, FEED_GOT_FIRST} wwdt_feed_type;
endpackage

/* wwdt_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wwdt_pkg::*;
    logic        clk, srst, psel, penable, pwrite, counting_clock, sleep_mode;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        pready, pslverr, chip_reset, warning_irq, wakeup, er, wake_seen;
    int          fail_count, cmp_count, cycles, n;
    wwdt_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counting_clock(counting_clock), .sleep_mode(sleep_mode), .chip_reset(chip_reset),
        .warning_irq(warning_irq), .wakeup(wakeup));
    // Bus clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counting clock, five bus cycles long and offset in phase.
    initial begin
        counting_clock = 1'b0;
        #3;
        forever #10 counting_clock = ~counting_clock;
    end
    // Cycle budget and a sticky record of wake-up pulses.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wakeup) wake_seen <= 1'b1;
        if (cycles == 60000) begin
            fail_count++;
            $display("unexpected at %0t: run too long", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access with its wait state; data and error kept in rd and er.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 {psel, penable, pwrite, paddr, pwdata} = {2'b10, w, a, d};
        @(posedge clk);
        #1 penable = 1'b1;
        for (n = 0; n < 8 && pready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        #1 {psel, penable} = 2'b00;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic feed();
        apb(1'b1, ADDR_FEED, {24'h0, FEED_FIRST});
        apb(1'b1, ADDR_FEED, {24'h0, FEED_SECOND});
    endtask
    task automatic wait_cc(input int k);
        repeat (k) @(posedge counting_clock);
        @(posedge clk);
        #1;
    endtask
    // Waits for the interrupt (irq high) or the reset pulse; n is the wait.
    task automatic wait_out(input logic irq, input int lim);
        for (n = 0; n < lim && (irq ? warning_irq : chip_reset) !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({31'h0, irq ? warning_irq : chip_reset}, 32'h1);
    endtask
    task automatic do_reset();
        srst = 1'b1;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
    endtask
    task automatic t_regs();
        rchk(ADDR_MODE, 32'h0);
        rchk(ADDR_RELOAD, 32'hFF);
        rchk(ADDR_READBACK, 32'hFF);
        rchk(ADDR_WARN, 32'h0);
        rchk(ADDR_WINDOW, 32'hFF_FFFF);
        rchk(32'h4000_4010, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, ADDR_RELOAD, 32'h10);
        rchk(ADDR_RELOAD, 32'hFF);
        apb(1'b1, ADDR_RELOAD, 32'h12_3456);
        rchk(ADDR_RELOAD, 32'h12_3456);
        apb(1'b1, ADDR_WARN, 32'hFFFF_FFFF);
        rchk(ADDR_WARN, 32'h3FF);
    endtask
    task automatic t_int_mode();
        sleep_mode = 1'b1;
        apb(1'b1, ADDR_WARN, 32'h5);
        apb(1'b1, ADDR_RELOAD, 32'h100);
        apb(1'b1, ADDR_MODE, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h0);
        rchk(ADDR_MODE, 32'h1);
        wait_cc(6);
        feed();
        wait_cc(40);
        apb(1'b0, ADDR_READBACK, 32'h0);
        chk({31'h0, rd[23:0] > 24'hF0 && rd[23:0] < 24'hFC}, 32'h1);
        wait_out(1'b1, 8000);
        chk({31'h0, wake_seen}, 32'h1);
        rchk(ADDR_MODE, 32'h9);
        wait_cc(40);
        rchk(ADDR_MODE, 32'hD);
        apb(1'b1, ADDR_MODE, 32'h8);
        rchk(ADDR_MODE, 32'h1);
        apb(1'b1, ADDR_FEED, {24'h0, FEED_FIRST});
        apb(1'b0, ADDR_MODE, 32'h0);
        rchk(ADDR_MODE, 32'h5);
        sleep_mode = 1'b0;
    endtask
    task automatic t_reset_mode();
        do_reset();
        apb(1'b1, ADDR_MODE, 32'h3);
        wait_cc(6);
        feed();
        apb(1'b1, ADDR_FEED, {24'h0, FEED_FIRST});
        apb(1'b1, ADDR_WARN, 32'h0);
        wait_out(1'b0, 10);
        rchk(ADDR_MODE, 32'h4);
        apb(1'b1, ADDR_MODE, 32'h3);
        wait_cc(6);
        feed();
        wait_out(1'b0, 6000);
        chk({31'h0, n > 5060 && n < 5180}, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h3);
        wait_cc(6);
        feed();
        apb(1'b1, ADDR_WINDOW, 32'h10);
        wait_cc(6);
        feed();
        wait_out(1'b0, 10);
    endtask
    task automatic t_protect();
        apb(1'b1, ADDR_MODE, 32'h13);
        apb(1'b1, ADDR_MODE, 32'h0);
        rchk(ADDR_MODE, 32'h13);
        wait_cc(6);
        feed();
        apb(1'b1, ADDR_RELOAD, 32'h200);
        wait_out(1'b0, 60);
        rchk(ADDR_MODE, 32'h4);
        rchk(ADDR_RELOAD, 32'hFF);
    endtask
    // Main sequence.
    initial begin
        {srst, psel, penable, pwrite, sleep_mode, wake_seen} = 6'h20;
        {paddr, pwdata} = 64'h0;
        {fail_count, cmp_count, cycles} = {32'h0, 32'h0, 32'h0};
        do_reset();
        t_regs();
        t_int_mode();
        t_reset_mode();
        t_protect();
        end_of_test();
    end
endmodule // tb
`default_nettype wire

/* wwdt_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wwdt_top (
    // Clock and reset.
    input  wire  logic        clk,
    input  wire  logic        srst,
    // Register bus, APB style.
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [31:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Counting clock pin and power state.
    input  wire  logic        counting_clock,
    input  wire  logic        sleep_mode,
    // Watchdog outputs.
    output logic              chip_reset,
    output logic              warning_irq,
    output logic              wakeup
);
    import wwdt_pkg::*;

    logic [2:0]          cc_sync_reg;
    logic                cc_level_reg;
    logic [1:0]          prescale_reg;
    logic [1:0]          sync_cnt_reg;
    logic                sync_pend_reg;
    wwdt_mode_type       mode_reg;
    wwdt_mode_type       mode_sync_reg;
    wwdt_mode_type       mode_act_reg;
    logic                timeout_flag_reg;
    logic                warning_flag_reg;
    logic                armed_reg;
    logic [CNT_W-1:0]    reload_reg;
    logic [CNT_W-1:0]    reload_sync_reg;
    logic [CNT_W-1:0]    counter_reg;
    logic [CNT_W-1:0]    readback_reg;
    logic [CNT_W-1:0]    window_reg;
    logic [WARN_W-1:0]   warn_reg;
    logic                match_pend_reg;
    logic                reset_pend_reg;
    wwdt_feed_type       feed_state_reg;
    logic [31:0]         prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;
    logic                chip_reset_reg;
    logic                warning_irq_reg;
    logic                wakeup_reg;

    // Counting clock edge filtered by the last two stages, then divided by four.
    wire cc_edge   = (cc_sync_reg[1] == cc_sync_reg[2]) && cc_sync_reg[2] && !cc_level_reg;
    wire cnt_tick  = cc_edge && (prescale_reg == PRESCALE_LAST);
    wire wd_reset  = chip_reset_reg;

    // Bus decode; an access completes in the cycle pready is high.
    wire acc       = psel && penable && pready_reg;
    wire wr        = acc && pwrite;
    wire hit_mode  = paddr == ADDR_MODE;
    wire hit_rel   = paddr == ADDR_RELOAD;
    wire hit_feed  = paddr == ADDR_FEED;
    wire hit_rb    = paddr == ADDR_READBACK;
    wire hit_warn  = paddr == ADDR_WARN;
    wire hit_win   = paddr == ADDR_WINDOW;
    wire mapped    = hit_mode || hit_rel || hit_feed || hit_rb || hit_warn || hit_win;
    wire wr_first  = wr && hit_feed && (pwdata[7:0] == FEED_FIRST);
    wire wr_second = wr && hit_feed && (pwdata[7:0] == FEED_SECOND);

    // Feed completion and feed errors.
    wire feed_done = (feed_state_reg == FEED_GOT_FIRST) && wr_second;
    wire feed_err  = (feed_state_reg == FEED_GOT_FIRST) && acc && !wr_second
                     && armed_reg;
    wire win_err   = feed_done && armed_reg && mode_act_reg.reset_on_timeout
                     && (counter_reg > window_reg);

    // Protected reload writes allowed only below both compare values.
    wire below_cmp = (counter_reg < {14'h0000, warn_reg}) && (counter_reg < window_reg);
    wire rel_ok    = !mode_reg.reload_protect || below_cmp;
    wire rel_err   = wr && hit_rel && !rel_ok;
    wire [CNT_W-1:0] rel_wval = (pwdata[CNT_W-1:0] < RELOAD_MIN) ? RELOAD_MIN
                                : pwdata[CNT_W-1:0];

    // Counter events, only while armed and enabled; reload errors reach tmo_set and rst_req at any time.
    wire running   = armed_reg && mode_act_reg.run_enable;
    wire warn_hit  = running && cnt_tick && (counter_reg[CNT_W-1:WARN_W] == 14'h0000)
                     && (counter_reg[WARN_W-1:0] == warn_reg);
    wire tmo_hit   = running && cnt_tick && (counter_reg == 24'h00_0000);
    wire tmo_rst   = tmo_hit && mode_act_reg.reset_on_timeout;
    wire tmo_set   = tmo_hit || feed_err || rel_err;
    wire rst_req   = tmo_rst || win_err || rel_err
                     || (feed_err && mode_act_reg.reset_on_timeout);
    wire warn_set  = match_pend_reg && cc_edge;

    // Read data selection.
    wire [31:0] rd_mode = {27'h000_0000, mode_reg.reload_protect, warning_flag_reg,
                           timeout_flag_reg, mode_reg.reset_on_timeout, mode_reg.run_enable};
    wire [31:0] rd_val  = hit_mode ? rd_mode :
                          hit_rel  ? {8'h00, reload_reg} :
                          hit_rb   ? {8'h00, readback_reg} :
                          hit_warn ? {22'h00_0000, warn_reg} :
                          hit_win  ? {8'h00, window_reg} : 32'h0000_0000;

    // Three stage input synchroniser and filtered level of the counting clock.
    always_ff @(posedge clk) begin
        if (srst) begin
            cc_sync_reg  <= 3'h0;
            cc_level_reg <= 1'b0;
        end else begin
            cc_sync_reg <= {cc_sync_reg[1:0], counting_clock};
            if (cc_sync_reg[1] == cc_sync_reg[2]) begin
                cc_level_reg <= cc_sync_reg[2];
            end
        end
    end

    // Divide by four prescaler on counting clock edges.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            prescale_reg <= 2'h0;
        end else if (cc_edge) begin
            prescale_reg <= prescale_reg + 2'h1;
        end
    end

    // Bus slave with one wait state; unmapped addresses answer with an error.
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            // Read data stands only while pready is high and is zero otherwise.
            if (psel && penable && !pready_reg && !pwrite) begin
                prdata_reg <= rd_val;
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Set-only mode bits and software compare registers.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            mode_reg   <= '0;
            reload_reg <= RELOAD_RESET;
            warn_reg   <= WARN_RESET;
            window_reg <= WINDOW_RESET;
        end else if (wr) begin
            if (hit_mode) begin
                mode_reg.run_enable       <= mode_reg.run_enable | pwdata[BIT_RUN_ENABLE];
                mode_reg.reset_on_timeout <= mode_reg.reset_on_timeout | pwdata[BIT_RESET_ON_TIMEOUT];
                mode_reg.reload_protect   <= mode_reg.reload_protect | pwdata[BIT_RELOAD_PROTECT];
            end
            if (hit_rel && rel_ok) begin
                reload_reg <= rel_wval;
            end
            if (hit_warn) begin
                warn_reg <= pwdata[WARN_W-1:0];
            end
            if (hit_win) begin
                window_reg <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Timeout flag survives a watchdog reset; the set wins over a clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            timeout_flag_reg <= 1'b0;
        end else if (tmo_set) begin
            timeout_flag_reg <= 1'b1;
        end else if (wr && hit_mode && !pwdata[BIT_TIMEOUT_FLAG]) begin
            timeout_flag_reg <= 1'b0;
        end
    end

    // Warning flag; a pending match lands one counting clock after the match.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            warning_flag_reg <= 1'b0;
            match_pend_reg   <= 1'b0;
        end else begin
            if (warn_hit) begin
                match_pend_reg <= 1'b1;
            end else if (warn_set) begin
                match_pend_reg <= 1'b0;
            end
            if (warn_set) begin
                warning_flag_reg <= 1'b1;
            end else if (wr && hit_mode && pwdata[BIT_WARNING_FLAG]) begin
                warning_flag_reg <= 1'b0;
            end
        end
    end

    // Mode and reload writes reach the counting side after three counting clock edges.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            sync_pend_reg   <= 1'b0;
            sync_cnt_reg    <= 2'h0;
            mode_sync_reg   <= '0;
            reload_sync_reg <= RELOAD_RESET;
        end else if (wr && (hit_mode || hit_rel)) begin
            sync_pend_reg <= 1'b1;
            sync_cnt_reg  <= SYNC_DELAY;
        end else if (sync_pend_reg && cc_edge) begin
            if (sync_cnt_reg == 2'h1) begin
                sync_pend_reg   <= 1'b0;
                mode_sync_reg   <= mode_reg;
                reload_sync_reg <= reload_reg;
            end
            sync_cnt_reg <= sync_cnt_reg - 2'h1;
        end
    end

    // Feed sequencer; every access after the first byte ends the sequence.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            feed_state_reg <= FEED_IDLE;
        end else if (acc) begin
            unique case (feed_state_reg)
                FEED_IDLE:      feed_state_reg <= wr_first ? FEED_GOT_FIRST : FEED_IDLE;
                FEED_GOT_FIRST: feed_state_reg <= FEED_IDLE;
            endcase
        end
    end

    // Run enable and reset on timeout take effect and the watchdog arms only on a completed feed.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            mode_act_reg <= '0;
            armed_reg    <= 1'b0;
        end else if (feed_done) begin
            mode_act_reg <= mode_sync_reg;
            armed_reg    <= mode_sync_reg.run_enable;
        end
    end

    // Down counter: reloaded on feed and on timeout, decremented per tick.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            counter_reg <= RELOAD_RESET;
        end else if (feed_done || tmo_hit) begin
            counter_reg <= reload_sync_reg;
        end else if (running && cnt_tick) begin
            counter_reg <= counter_reg - 24'h00_0001;
        end
    end

    // Readback snapshot taken on counting clock edges.
    always_ff @(posedge clk) begin
        if (srst || wd_reset) begin
            readback_reg <= RELOAD_RESET;
        end else if (cc_edge) begin
            readback_reg <= counter_reg;
        end
    end

    // Reset pipeline: asserted in the second cycle after the cause.
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_pend_reg  <= 1'b0;
            chip_reset_reg  <= 1'b0;
            warning_irq_reg <= 1'b0;
            wakeup_reg      <= 1'b0;
        end else begin
            reset_pend_reg  <= rst_req && !wd_reset;
            chip_reset_reg  <= reset_pend_reg;
            warning_irq_reg <= warning_flag_reg && mode_act_reg.run_enable;
            wakeup_reg      <= warn_set && sleep_mode;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign chip_reset  = chip_reset_reg;
    assign warning_irq = warning_irq_reg;
    assign wakeup      = wakeup_reg;
endmodule // wwdt_top
`default_nettype wire
